/* rtl/kms_pkg.sv */
package kms_pkg;

  // Clock and timing figures, all times in nanoseconds.
  localparam int unsigned KMS_CLK_PERIOD_NS = 50;
  localparam int unsigned KMS_SCAN_BASE_NS  = 500000;  // Shortest scan interval, 0.5 ms.
  localparam int unsigned KMS_MS_NS         = 1000000; // Debounce step, 1 ms.
  localparam int unsigned KMS_SETTLE_NS     = 1000;    // Column settle time before the rows are sampled.
  localparam int unsigned KMS_SETTLE_CYC    = (KMS_SETTLE_NS + KMS_CLK_PERIOD_NS - 1) / KMS_CLK_PERIOD_NS;

  // Limits of the block.
  localparam int unsigned KMS_MAX_KEYS  = 108;
  localparam int unsigned KMS_NUM_WORDS = 4;
  localparam int unsigned KMS_DB_W      = 6;
  localparam int unsigned KMS_IDX_COL_LSB = 14;

  // Register byte offsets.
  localparam logic [7:0] KMS_OFF_CTRL   = 8'h00;
  localparam logic [7:0] KMS_OFF_DEB    = 8'h04;
  localparam logic [7:0] KMS_OFF_KEYCFG = 8'h08;
  localparam logic [7:0] KMS_OFF_STATUS = 8'h0c;
  localparam logic [7:0] KMS_OFF_WORD0  = 8'h10;
  localparam logic [7:0] KMS_OFF_LAST   = 8'h1c;

  // Field positions.
  localparam int unsigned KMS_CTRL_EN_BIT  = 0;
  localparam int unsigned KMS_CTRL_IVL_LSB = 1;
  localparam int unsigned KMS_CTRL_COL_LSB = 4;
  localparam int unsigned KMS_CTRL_ROW_LSB = 8;
  localparam int unsigned KMS_DEB_PRS_LSB  = 0;
  localparam int unsigned KMS_DEB_REL_LSB  = 8;
  localparam int unsigned KMS_KEY_REG_LSB  = 0;
  localparam int unsigned KMS_KEY_SPC_LSB  = 8;
  localparam int unsigned KMS_STAT_CNT_LSB = 0;
  localparam int unsigned KMS_STAT_OVF_BIT = 3;
  localparam int unsigned KMS_STAT_CFG_BIT = 4;
  localparam int unsigned KMS_STAT_BSY_BIT = 5;

  // Values after reset.
  localparam logic       KMS_RST_EN   = 1'b0;
  localparam logic [1:0] KMS_RST_IVL  = 2'h0;
  localparam logic [3:0] KMS_RST_COLS = 4'he;
  localparam logic [3:0] KMS_RST_ROWS = 4'he;
  localparam logic [5:0] KMS_RST_DBP  = 6'h05;
  localparam logic [5:0] KMS_RST_DBR  = 6'h05;
  localparam logic [6:0] KMS_RST_NREG = 7'h64;
  localparam logic [6:0] KMS_RST_NSPC = 7'h08;

  // One key status word: press flag, multi-key flag, column/row index.
  typedef struct packed {
    logic        press;
    logic        multi;
    logic [27:0] idx;
  } kms_word_t;

  typedef enum logic [1:0] {
    KMS_IDLE  = 2'b00,
    KMS_DRIVE = 2'b01,
    KMS_EVAL  = 2'b10,
    KMS_DONE  = 2'b11
  } kms_state_t;

endpackage

/* rtl/kms_top.sv */
// How it works
// - Columns are driven one at a time and rows sensed to locate each key.
// - Full-scan interval is software selectable: 0.5, 1, 2 or 4 ms.
// - After a scan with any key change, store status and pulse an interrupt.
// - Status word: press flag, multi-key flag, then 28-bit column/row index.
// - First flag tells whether the reported key was pressed or released.
// - Second flag set when the next word was filled for the same scan.
// - Words fill in a chain; a word fills only if the previous flags multi.
// - At most four status words are recorded per scan.
// - Column and row counts come from control register fields.
// - Regular and special key counts are programmable; total capped at 108.
// - Debounce rejects glitches shorter than 0..63 ms; zero disables it.
// - Press and release debounce times are programmed separately.
// - Each interrupt source is its own parallel output pulse.
// - All control and status registers are reached over an APB slave.
module kms_top
  import kms_pkg::*;
#(
  parameter int unsigned MAX_COLS      = 14,
  parameter int unsigned MAX_ROWS      = 14,
  parameter int unsigned SCAN_BASE_CYC = KMS_SCAN_BASE_NS / KMS_CLK_PERIOD_NS,
  parameter int unsigned MS_CYC        = KMS_MS_NS / KMS_CLK_PERIOD_NS
) (
  input  wire logic                sys_clk,  // System clock, 20 MHz.
  input  wire logic                rst_b,    // Synchronous reset, active low.
  input  wire logic                clk_en,   // Freezes all state while low.
  input  wire logic                psel,     // APB select.
  input  wire logic                penable,  // APB access phase.
  input  wire logic                pwrite,   // APB write when high.
  input  wire logic [7:0]          paddr,    // APB byte address.
  input  wire logic [31:0]         pwdata,   // APB write data.
  output logic      [31:0]         prdata,   // APB read data.
  output logic                     pready,   // APB ready.
  output logic                     pslverr,  // APB error on unmapped address.
  output logic      [MAX_COLS-1:0] col_level, // Column pin output value, always low.
  output logic      [MAX_COLS-1:0] col_oe,    // Column pin enable, high while pulling low.
  input  wire logic [MAX_ROWS-1:0] row_sense, // Row pins, low when a key on the driven column is down.
  output logic                     irq_key,   // Pulse: scan finished with key changes.
  output logic                     irq_ovf    // Pulse: more changes than status words.
);

  localparam int unsigned NK    = MAX_COLS * MAX_ROWS;
  localparam int unsigned CW    = $clog2(MAX_COLS);
  localparam int unsigned RW    = $clog2(MAX_ROWS);
  localparam int unsigned KW    = $clog2(NK);
  localparam int unsigned IVL_W = $clog2(8 * SCAN_BASE_CYC + 1);
  localparam int unsigned MS_W  = $clog2(MS_CYC + 1);
  localparam int unsigned ST_W  = $clog2(KMS_SETTLE_CYC + 1);

  // Configuration registers.
  logic                en_q;
  logic [1:0]          ivl_q;
  logic [3:0]          ncols_q, nrows_q;
  logic [5:0]          dbp_q, dbr_q;
  logic [6:0]          nreg_q, nspc_q;
  // Scan state.
  kms_state_t          st_q;
  logic [CW-1:0]       col_q;
  logic [RW-1:0]       row_q;
  logic [ST_W-1:0]     settle_q;
  logic [MAX_ROWS-1:0] smp_q;
  logic [MAX_COLS-1:0] col_oe_q;
  logic [IVL_W-1:0]    ivl_cnt_q;
  logic [MS_W-1:0]     ms_cnt_q;
  // Per-key debounce state.
  logic [NK-1:0]       raw_q, stable_q;
  logic [KMS_DB_W-1:0] cnt_q [NK];
  // Chain of words gathered during a scan, and the published copy.
  kms_word_t           wbuf_q [KMS_NUM_WORDS];
  kms_word_t           stat_q [KMS_NUM_WORDS];
  logic [2:0]          nchg_q, last_cnt_q;
  logic                ovf_q, last_ovf_q, irq_key_q, irq_ovf_q;
  // APB state.
  logic                apb_vld_q, apb_err_q;
  logic [31:0]         prdata_q;
  // Derived scan terms.
  logic [IVL_W-1:0]    ivl_lim;
  logic                scan_due, ms_tick, cfg_err, key_ok, smp_bit, accept, eval_go;
  logic [CW-1:0]       last_col;
  logic [RW-1:0]       last_row;
  logic [7:0]          key_total, key_lim, lin_idx;
  logic [KW-1:0]       key_idx;
  logic [5:0]          thr;
  kms_word_t           cur_word;

  // The interval base is shifted by the select field, giving 1x, 2x, 4x or 8x of 0.5 ms.
  assign ivl_lim  = IVL_W'(SCAN_BASE_CYC) << ivl_q;
  assign scan_due = en_q && (ivl_cnt_q == ivl_lim - IVL_W'(1));
  assign ms_tick  = (ms_cnt_q == MS_W'(MS_CYC - 1));

  // Counts of zero are taken as one so the scan always ends.
  assign last_col  = (ncols_q == 4'h0) ? '0 : CW'(ncols_q - 4'h1);
  assign last_row  = (nrows_q == 4'h0) ? '0 : RW'(nrows_q - 4'h1);
  assign key_total = {1'b0, nreg_q} + {1'b0, nspc_q};
  assign cfg_err   = key_total > 8'(KMS_MAX_KEYS);
  assign key_lim   = cfg_err ? 8'(KMS_MAX_KEYS) : key_total;
  assign lin_idx   = 8'(col_q) * 8'(nrows_q) + 8'(row_q);
  assign key_ok    = (lin_idx < key_lim);
  assign key_idx   = KW'(col_q * MAX_ROWS) + KW'(row_q);
  assign smp_bit   = smp_q[row_q];
  assign eval_go   = (st_q == KMS_EVAL) && key_ok;

  // A held key changes to released under the release time, and the reverse for press.
  assign thr    = stable_q[key_idx] ? dbr_q : dbp_q;
  assign accept = eval_go && (smp_bit != stable_q[key_idx]) && (cnt_q[key_idx] >= thr);

  // Index field carries the row in the low bits and the column above it.
  always_comb begin
    cur_word       = '0;
    cur_word.press = smp_bit;
    cur_word.idx[RW-1:0] = row_q;
    cur_word.idx[KMS_IDX_COL_LSB +: CW] = col_q;
  end

  // The interval timer runs only while scanning is enabled; the millisecond timer runs whenever clk_en is high.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ivl_cnt_q <= '0;
      ms_cnt_q  <= '0;
    end else if (clk_en) begin
      ivl_cnt_q <= (!en_q || scan_due) ? '0 : ivl_cnt_q + IVL_W'(1);
      ms_cnt_q  <= ms_tick ? '0 : ms_cnt_q + MS_W'(1);
    end
  end

  // Scan sequencer: drive a column, let it settle, sample rows, then judge keys one per cycle.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      st_q     <= KMS_IDLE;
      col_q    <= '0;
      row_q    <= '0;
      settle_q <= '0;
      smp_q    <= '0;
      col_oe_q <= '0;
    end else if (clk_en) begin
      unique case (st_q)
        KMS_IDLE: begin
          if (scan_due) begin
            st_q     <= KMS_DRIVE;
            col_q    <= '0;
            settle_q <= '0;
            col_oe_q <= MAX_COLS'(1);
          end
        end
        KMS_DRIVE: begin
          settle_q <= settle_q + ST_W'(1);
          if (settle_q == ST_W'(KMS_SETTLE_CYC - 1)) begin
            smp_q    <= ~row_sense;
            row_q    <= '0;
            col_oe_q <= '0;
            st_q     <= KMS_EVAL;
          end
        end
        KMS_EVAL: begin
          row_q <= row_q + RW'(1);
          if (row_q >= last_row) begin
            if (col_q >= last_col) begin
              st_q <= KMS_DONE;
            end else begin
              col_q    <= col_q + CW'(1);
              settle_q <= '0;
              col_oe_q <= MAX_COLS'(1) << (col_q + CW'(1));
              st_q     <= KMS_DRIVE;
            end
          end
        end
        KMS_DONE: begin
          st_q <= KMS_IDLE;
        end
      endcase
    end
  end

  // Each key keeps its last raw sample, its accepted state and the milliseconds it has disagreed.
  for (genvar k = 0; k < NK; k++) begin : g_key
    logic hit;
    assign hit = eval_go && (key_idx == KW'(k));
    always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
        raw_q[k]    <= 1'b0;
        stable_q[k] <= 1'b0;
        cnt_q[k]    <= '0;
      end else if (clk_en) begin
        if (hit) begin
          raw_q[k] <= smp_bit;
          if (accept) begin
            stable_q[k] <= smp_bit;
          end
          if (accept || smp_bit == stable_q[k]) begin
            cnt_q[k] <= '0;
          end
        end else if (ms_tick && raw_q[k] != stable_q[k] && cnt_q[k] != '1) begin
          cnt_q[k] <= cnt_q[k] + KMS_DB_W'(1);
        end
      end
    end
  end

  // Accepted changes queue into the chain; a fifth change only marks overflow.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      nchg_q <= '0;
      ovf_q  <= 1'b0;
      for (int i = 0; i < KMS_NUM_WORDS; i++) begin
        wbuf_q[i] <= '0;
      end
    end else if (clk_en) begin
      if (st_q == KMS_IDLE) begin
        nchg_q <= '0;
        ovf_q  <= 1'b0;
      end else if (accept) begin
        if (nchg_q < 3'(KMS_NUM_WORDS)) begin
          wbuf_q[nchg_q[1:0]] <= cur_word;
          nchg_q <= nchg_q + 3'h1;
        end else begin
          ovf_q <= 1'b1;
        end
      end
    end
  end

  // Publishing happens once per scan and only if something changed, so old words survive quiet scans.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      last_cnt_q <= '0;
      last_ovf_q <= 1'b0;
      irq_key_q  <= 1'b0;
      irq_ovf_q  <= 1'b0;
      for (int i = 0; i < KMS_NUM_WORDS; i++) begin
        stat_q[i] <= '0;
      end
    end else if (clk_en) begin
      irq_key_q <= (st_q == KMS_DONE) && (nchg_q != 3'h0);
      irq_ovf_q <= (st_q == KMS_DONE) && ovf_q;
      if (st_q == KMS_DONE && nchg_q != 3'h0) begin
        last_cnt_q <= nchg_q;
        last_ovf_q <= ovf_q;
        for (int i = 0; i < KMS_NUM_WORDS; i++) begin
          if (3'(i) < nchg_q) begin
            stat_q[i]       <= wbuf_q[i];
            stat_q[i].multi <= (3'(i + 1) < nchg_q);
          end else begin
            stat_q[i] <= '0;
          end
        end
      end
    end
  end

  // APB answers with no wait state: the setup cycle latches read data and the decode result.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      apb_vld_q <= 1'b0;
      apb_err_q <= 1'b0;
      prdata_q  <= '0;
    end else if (clk_en) begin
      if (pready) begin
        apb_vld_q <= 1'b0;
      end else if (psel && !apb_vld_q) begin
        apb_vld_q <= 1'b1;
        apb_err_q <= (paddr > KMS_OFF_LAST) || (paddr[1:0] != 2'h0);
        prdata_q  <= '0;
        unique case (paddr)
          KMS_OFF_CTRL: begin
            prdata_q[KMS_CTRL_EN_BIT]        <= en_q;
            prdata_q[KMS_CTRL_IVL_LSB +: 2]  <= ivl_q;
            prdata_q[KMS_CTRL_COL_LSB +: 4]  <= ncols_q;
            prdata_q[KMS_CTRL_ROW_LSB +: 4]  <= nrows_q;
          end
          KMS_OFF_DEB: begin
            prdata_q[KMS_DEB_PRS_LSB +: 6]   <= dbp_q;
            prdata_q[KMS_DEB_REL_LSB +: 6]   <= dbr_q;
          end
          KMS_OFF_KEYCFG: begin
            prdata_q[KMS_KEY_REG_LSB +: 7]   <= nreg_q;
            prdata_q[KMS_KEY_SPC_LSB +: 7]   <= nspc_q;
          end
          KMS_OFF_STATUS: begin
            prdata_q[KMS_STAT_CNT_LSB +: 3]  <= last_cnt_q;
            prdata_q[KMS_STAT_OVF_BIT]       <= last_ovf_q;
            prdata_q[KMS_STAT_CFG_BIT]       <= cfg_err;
            prdata_q[KMS_STAT_BSY_BIT]       <= (st_q != KMS_IDLE);
          end
          KMS_OFF_WORD0, KMS_OFF_WORD0 + 8'h04,
          KMS_OFF_WORD0 + 8'h08, KMS_OFF_LAST: begin
            prdata_q[29:0] <= stat_q[paddr[3:2]];
          end
          default: begin
            prdata_q <= '0;
          end
        endcase
      end
    end
  end

  // Software writes to the configuration; status words are read only and writes to them are dropped.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      en_q    <= KMS_RST_EN;
      ivl_q   <= KMS_RST_IVL;
      ncols_q <= KMS_RST_COLS;
      nrows_q <= KMS_RST_ROWS;
      dbp_q   <= KMS_RST_DBP;
      dbr_q   <= KMS_RST_DBR;
      nreg_q  <= KMS_RST_NREG;
      nspc_q  <= KMS_RST_NSPC;
    end else if (clk_en && pready && pwrite && !apb_err_q) begin
      if (paddr == KMS_OFF_CTRL) begin
        en_q    <= pwdata[KMS_CTRL_EN_BIT];
        ivl_q   <= pwdata[KMS_CTRL_IVL_LSB +: 2];
        ncols_q <= pwdata[KMS_CTRL_COL_LSB +: 4];
        nrows_q <= pwdata[KMS_CTRL_ROW_LSB +: 4];
      end
      if (paddr == KMS_OFF_DEB) begin
        dbp_q <= pwdata[KMS_DEB_PRS_LSB +: 6];
        dbr_q <= pwdata[KMS_DEB_REL_LSB +: 6];
      end
      if (paddr == KMS_OFF_KEYCFG) begin
        nreg_q <= pwdata[KMS_KEY_REG_LSB +: 7];
        nspc_q <= pwdata[KMS_KEY_SPC_LSB +: 7];
      end
    end
  end

  // Ready is held back while the clock enable is low so no access is lost.
  assign pready    = psel && penable && apb_vld_q && clk_en;
  assign pslverr   = pready && apb_err_q;
  assign prdata    = prdata_q;
  assign col_level = '0;
  assign col_oe    = col_oe_q;
  assign irq_key   = irq_key_q;
  assign irq_ovf   = irq_ovf_q;

endmodule

/* verif/kms_keys.sv */
module kms_keys
  import kms_pkg::*;
#(
  parameter int unsigned NCOL = 14,
  parameter int unsigned NROW = 14
) (
  input  wire logic [NCOL-1:0]      col_oe,   // Column pull-down enables.
  input  wire logic [NCOL*NROW-1:0] key_down, // Closed switches, column*NROW+row.
  output logic      [NROW-1:0]      row_sense // Row lines with pull-ups.
);
  timeunit 1ns;
  timeprecision 1ps;
  // A closed switch joins row and column; a released row floats up to its pull-up.
  always_comb begin
    row_sense = '1;
    for (int c = 0; c < NCOL; c++) begin
      for (int r = 0; r < NROW; r++) begin
        if (col_oe[c] && key_down[c*NROW+r]) begin
          row_sense[r] = 1'b0;
        end
      end
    end
  end
endmodule

/* verif/kms_chk.sv */
module kms_chk
  import kms_pkg::*;
#(
  parameter int unsigned MAX_COLS = 14,
  parameter int unsigned MAX_ROWS = 14
) (
  input wire logic                sys_clk,   // Clock.
  input wire logic                rst_b,     // Reset, active low.
  input wire logic                clk_en,    // Clock enable.
  input wire logic                psel,      // APB select.
  input wire logic                penable,   // APB enable.
  input wire logic                pready,    // APB ready.
  input wire logic                pslverr,   // APB error.
  input wire logic [7:0]          paddr,     // APB address.
  input wire logic [MAX_COLS-1:0] col_oe,    // Column enables.
  input wire logic                irq_key,   // Key change pulse.
  input wire logic                irq_ovf    // Overflow pulse.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [MAX_COLS-1:0] oe_prev_q;
  logic [7:0]          oe_run_q;
  // Length of the present column drive; a counter keeps the 20-cycle check cheap.
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      oe_prev_q <= '0;
      oe_run_q  <= 8'h00;
    end else if (clk_en) begin
      oe_prev_q <= col_oe;
      oe_run_q  <= (col_oe != oe_prev_q) ? 8'h01 : oe_run_q + 8'h01;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence s_setup;
    psel && !penable && clk_en;
  endsequence
  sequence s_access;
    psel && penable && clk_en;
  endsequence

  chk_oe_onehot: assert property ($onehot0(col_oe))
    else $error("more than one column driven");
  chk_oe_settle: assert property ((oe_prev_q != '0 && col_oe != oe_prev_q) |-> oe_run_q == KMS_SETTLE_CYC)
    else $error("column drive length wrong");
  chk_rdy_wait: assert property (s_setup ##1 s_access |-> pready)
    else $error("apb ready timing wrong");
  chk_rdy_pulse: assert property (pready |=> !pready)
    else $error("apb ready longer than one cycle");
  chk_err_addr: assert property (pready |-> pslverr == (paddr > 8'h1c || paddr[1:0] != 2'b00))
    else $error("apb error flag wrong");
  chk_irq_pulse: assert property (irq_key |=> !irq_key)
    else $error("key interrupt not a pulse");
  chk_irq_idle: assert property (irq_key |-> col_oe == '0 && $past(col_oe) == '0)
    else $error("key interrupt during scan");
  chk_ovf_key: assert property (irq_ovf |-> irq_key)
    else $error("overflow without key interrupt");
endmodule

/* verif/tb_top.sv */
module tb_top
  import kms_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned BASE = 200;
  localparam int unsigned MSC  = 10;
  logic         sys_clk, rst_b, clk_en, psel, penable, pwrite, pready, pslverr, irq_key, irq_ovf;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata;
  logic [13:0]  col_level, col_oe, row_sense;
  logic [195:0] key_down;
  int           err_total, n_tests, at;
  logic         ovf;

  kms_top #(.SCAN_BASE_CYC(BASE), .MS_CYC(MSC)) dut (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .col_level(col_level), .col_oe(col_oe), .row_sense(row_sense),
    .irq_key(irq_key), .irq_ovf(irq_ovf));
  kms_keys u_keys (.col_oe(col_oe), .key_down(key_down), .row_sense(row_sense));

  // Free-running 20 MHz clock.
  always #25 sys_clk = ~sys_clk;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // One APB transfer; the request stands until ready is sampled high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic err);
    int n;
    @(posedge sys_clk); #1;
    psel = 1'b1; pwrite = wr; paddr = a; pwdata = d;
    @(posedge sys_clk); #1;
    penable = 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 8);
    q = prdata;
    err = pslverr;
    if (pready === 1'b1) begin
      #1;
      psel = 1'b0;
      penable = 1'b0;
    end else begin
      check("apb ready", 32'h0, 32'h1);
      finish_test();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    check(what, q, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  // Bounded wait for the key interrupt; at is zero when none came.
  task automatic wait_irq(input int lim);
    at = 0;
    ovf = 1'b0;
    for (int i = 1; i <= lim && at == 0; i++) begin
      @(posedge sys_clk);
      if (irq_key === 1'b1) begin
        at = i;
        ovf = irq_ovf;
      end
    end
    // Step off the edge so that stimulus after the wait never races the design's sampling.
    #1;
  endtask

  task automatic words4(input logic [127:0] e);
    for (int i = 0; i < 4; i++) rd(KMS_OFF_WORD0 + 8'(4*i), e[127-32*i -: 32], "status word");
  endtask

  task automatic t_regs();
    logic [31:0] q;
    logic        e;
    rd(KMS_OFF_CTRL, 32'h00000ee0, "ctrl reset");
    rd(KMS_OFF_DEB, 32'h00000505, "debounce reset");
    rd(KMS_OFF_KEYCFG, 32'h00000864, "keycfg reset");
    check("column level", 32'(col_level), 32'h0);
    apb(1'b0, 8'h20, 32'h0, q, e);
    check("unmapped error", {31'h0, e}, 32'h1);
    apb(1'b1, 8'h06, 32'h0, q, e);
    check("misaligned error", {31'h0, e}, 32'h1);
    wr(KMS_OFF_KEYCFG, 32'h00000964);
    rd(KMS_OFF_STATUS, 32'h00000010, "key total limit");
    wr(KMS_OFF_KEYCFG, 32'h00000864);
    wr(KMS_OFF_DEB, 32'h00000000);
    rd(KMS_OFF_DEB, 32'h00000000, "debounce write");
    wr(KMS_OFF_CTRL, 32'h00000321);
    rd(KMS_OFF_CTRL, 32'h00000321, "ctrl write");
    $display("test regs done");
  endtask

  task automatic t_single();
    key_down[16] = 1'b1;
    wait_irq(600);
    check("press irq", 32'(at != 0), 32'h1);
    words4({32'h20004002, 96'h0});
    rd(KMS_OFF_STATUS, 32'h00000001, "one word");
    key_down[16] = 1'b0;
    wait_irq(600);
    check("release irq", 32'(at != 0), 32'h1);
    rd(KMS_OFF_WORD0, 32'h00004002, "release word");
    wait_irq(450);
    check("quiet scan irq", 32'(at), 32'h0);
    rd(KMS_OFF_WORD0, 32'h00004002, "word holds");
    $display("test single done");
  endtask

  // Keys change just after a scan starts, so every change of a step lands in one scan.
  task automatic t_multi();
    int n;
    next_scan(n);
    #1;
    key_down[2:0] = 3'b111;
    key_down[16:14] = 3'b111;
    wait_irq(600);
    check("overflow irq", {31'h0, ovf}, 32'h1);
    words4({32'h30000000, 32'h30000001, 32'h30000002, 32'h20004000});
    rd(KMS_OFF_STATUS, 32'h0000000c, "overflow status");
    next_scan(n);
    #1;
    key_down = '0;
    wait_irq(600);
    check("group release irq", 32'(at != 0), 32'h1);
    next_scan(n);
    #1;
    key_down[1] = 1'b1;
    key_down[15] = 1'b1;
    wait_irq(600);
    words4({32'h30000001, 32'h20004001, 64'h0});
    next_scan(n);
    #1;
    key_down = '0;
    wait_irq(600);
    check("pair release irq", 32'(at != 0), 32'h1);
    $display("test multi done");
  endtask

  task automatic t_debounce();
    wr(KMS_OFF_DEB, 32'h0000003f);
    key_down[16] = 1'b1;
    repeat (230) @(posedge sys_clk);
    #1 key_down[16] = 1'b0;
    wait_irq(700);
    check("glitch rejected", 32'(at), 32'h0);
    key_down[16] = 1'b1;
    wait_irq(500);
    check("press held early", 32'(at), 32'h0);
    wait_irq(1000);
    check("press accepted", 32'(at != 0), 32'h1);
    key_down[16] = 1'b0;
    wait_irq(300);
    check("fast release", 32'(at != 0), 32'h1);
    rd(KMS_OFF_WORD0, 32'h00004002, "debounced release");
    $display("test debounce done");
  endtask

  // Counts edges from one scan start to the next.
  task automatic next_scan(output int n);
    n = 0;
    while (col_oe[0] !== 1'b0 && n < 4000) begin
      @(posedge sys_clk);
      n++;
    end
    while (col_oe[0] !== 1'b1 && n < 4000) begin
      @(posedge sys_clk);
      n++;
    end
  endtask

  task automatic t_interval();
    int n;
    for (int s = 0; s < 4; s++) begin
      wr(KMS_OFF_CTRL, 32'h00000321 | (32'(s) << 1));
      next_scan(n);
      next_scan(n);
      check("scan interval", 32'(n), 32'(BASE << s));
    end
    $display("test interval done");
  endtask

  initial begin
    sys_clk = 1'b0; rst_b = 1'b0; clk_en = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; key_down = '0; err_total = 0; n_tests = 0;
    repeat (8) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    t_regs();
    t_single();
    t_multi();
    t_debounce();
    t_interval();
    finish_test();
  end
endmodule

bind kms_top kms_chk #(.MAX_COLS(MAX_COLS), .MAX_ROWS(MAX_ROWS)) u_chk (.sys_clk(sys_clk), .rst_b(rst_b),
  .clk_en(clk_en), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .paddr(paddr),
  .col_oe(col_oe), .irq_key(irq_key), .irq_ovf(irq_ovf));
